// file: hdl/pcg_top.sv
// pcg_top: peripheral clock gating controller with apb register port.
// assumes: apb master per protocol, system clock MCLK, sync reset SRST,
// unit access strobes come from the peripheral bus decoder.
//
// Contract
// - each gating bit drives its unit clock enable, 1 runs, 0 stops.
// - an access to a unit whose clock is off is answered with a fault.
// - gating bits reset to zero unless given another reset value.
// - bit 6 is read-write, gates the hibernation unit, resets to 1.
// - bit 3 is read-write, gates the watchdog, resets to 0.
// - bit 20 of the sleep register gates the pwm unit, resets to 0.
// - bit 16 of the sleep register gates adc zero, resets to 0.
// - bits 9:8 pick adc speed 2=500k, 1=250k, 0=125k, reset 0.
// - the effective adc speed never exceeds the device maximum.
// - run, sleep and deep-sleep gating registers are kept apart.
// - sleep registers apply only when automatic gating is selected.
// - reserved bits are read-only zero; software preserves them.
// - the sleep gating register sits at offset 0x110.
// - the run gating register sits at 0x100, reset 0x00000040.
`timescale 1ns/1ns
`default_nettype none
module pcg_top
  import pcg_pkg::*;
#(
  parameter logic [1:0] MAX_SPD = PCG_SPD_500K
) (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        SRST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // power mode from the system power controller
  input  wire logic [1:0]  PWR_MODE,
  // unit access strobes: pwm, adc, hib, wdt
  input  wire logic [3:0]  UNIT_SEL,
  output logic [3:0]       UNIT_FAULT,
  // unit clock enables
  output logic             PWM_CLK_EN,
  output logic             ADC_CLK_EN,
  output logic             HIB_CLK_EN,
  output logic             WDT_CLK_EN,
  output logic [1:0]       ADC_SPEED,
  // interrupt
  output logic             IRQ
);

  import pcg_pkg::*;

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  logic [31:0]  run_reg;
  logic [31:0]  slp_reg;
  logic [31:0]  dslp_reg;
  logic [31:0]  cfg_reg;
  logic [3:0]   stat_reg;
  logic [3:0]   mask_reg;
  logic         pready_reg;
  pcg_apb_req_t req;
  pcg_gates_t   gates;
  pcg_pmode_t   pmode;
  logic [3:0]   fault_now;
  logic         wr_take;
  logic         rd_take;
  logic         auto_sel;

  assign req      = '{sel: PSEL, en: PENABLE, wr: PWRITE,
                      addr: PADDR, wdata: PWDATA};
  assign auto_sel = cfg_reg[PCG_BIT_AUTO];
  // undefined mode code treated as run
  assign pmode    = (PWR_MODE == 2'b01) ? PCG_PM_SLEEP :
                    (PWR_MODE == 2'b10) ? PCG_PM_DEEP : PCG_PM_RUN;

  // one wait state: answer in the second access cycle
  assign wr_take = req.sel & req.en & pready_reg & req.wr;
  assign rd_take = req.sel & req.en & ~pready_reg & ~req.wr;

  function automatic logic addr_known(input logic [11:0] a);
    return (a == PCG_OFF_RUN_CFG)   || (a == PCG_OFF_RUN_GATE)  ||
           (a == PCG_OFF_SLP_GATE)  || (a == PCG_OFF_DSLP_GATE) ||
           (a == PCG_OFF_INT_STAT)  || (a == PCG_OFF_INT_MASK)  ||
           (a == PCG_OFF_MODE);
  endfunction : addr_known

  function automatic logic [31:0] gate_write(input logic [31:0] d);
    // reserved positions never store, so they read back as zero
    return d & PCG_GATE_WMASK;
  endfunction : gate_write

  // pending write-one-to-clear mask, zero unless the status word is hit
  function automatic logic [3:0] clr_now();
    return (wr_take && req.addr == PCG_OFF_INT_STAT) ? req.wdata[3:0] : 4'h0;
  endfunction : clr_now

  // ------------------------------------------------------------------
  // apb handshake
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pready_reg <= 1'b0;
    end else if (req.sel && req.en && !pready_reg) begin
      pready_reg <= 1'b1;
    end else begin
      pready_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= req.sel && req.en && !pready_reg && !addr_known(req.addr);
    end
  end

  assign PREADY = pready_reg;

  // ------------------------------------------------------------------
  // gating registers
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      run_reg <= PCG_GATE_RESET;
    end else if (wr_take && req.addr == PCG_OFF_RUN_GATE) begin
      run_reg <= gate_write(req.wdata);
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      slp_reg <= PCG_GATE_RESET;
    end else if (wr_take && req.addr == PCG_OFF_SLP_GATE) begin
      slp_reg <= gate_write(req.wdata);
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      dslp_reg <= PCG_GATE_RESET;
    end else if (wr_take && req.addr == PCG_OFF_DSLP_GATE) begin
      dslp_reg <= gate_write(req.wdata);
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      cfg_reg <= PCG_CFG_RESET;
    end else if (wr_take && req.addr == PCG_OFF_RUN_CFG) begin
      cfg_reg <= req.wdata & PCG_CFG_WMASK;
    end
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_take) begin
      case (req.addr)
        PCG_OFF_RUN_GATE:  PRDATA <= run_reg;
        PCG_OFF_SLP_GATE:  PRDATA <= slp_reg;
        PCG_OFF_DSLP_GATE: PRDATA <= dslp_reg;
        PCG_OFF_RUN_CFG:   PRDATA <= cfg_reg;
        PCG_OFF_INT_STAT:  PRDATA <= {28'h0000000, stat_reg};
        PCG_OFF_INT_MASK:  PRDATA <= {28'h0000000, mask_reg};
        PCG_OFF_MODE:      PRDATA <= {29'h00000000, auto_sel, pmode};
        default:           PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // gate selection and fault detection
  // ------------------------------------------------------------------
  pcg_gate_sel #(
    .MAX_SPD (MAX_SPD)
  ) u_sel (
    .run_word  (run_reg),
    .slp_word  (slp_reg),
    .dslp_word (dslp_reg),
    .auto_sel  (auto_sel),
    .pmode     (pmode),
    .gates     (gates)
  );

  pcg_fault_chk u_fault (
    .unit_sel   (UNIT_SEL),
    .gates      (gates),
    .unit_fault (fault_now)
  );

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      PWM_CLK_EN <= PCG_GATE_RESET[PCG_BIT_PWM];
      ADC_CLK_EN <= PCG_GATE_RESET[PCG_BIT_ADC];
      HIB_CLK_EN <= PCG_GATE_RESET[PCG_BIT_HIB];
      WDT_CLK_EN <= PCG_GATE_RESET[PCG_BIT_WDT];
      ADC_SPEED  <= PCG_SPD_125K;
    end else begin
      PWM_CLK_EN <= gates.pwm;
      ADC_CLK_EN <= gates.adc;
      HIB_CLK_EN <= gates.hibernation_gate;
      WDT_CLK_EN <= gates.wdt;
      ADC_SPEED  <= gates.spd;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      UNIT_FAULT <= 4'h0;
    end else begin
      UNIT_FAULT <= fault_now;
    end
  end

  // ------------------------------------------------------------------
  // interrupt: sticky fault flags, write one to clear, set wins
  // ------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      stat_reg <= 4'h0;
    end else begin
      // a fault in the clearing cycle survives the clear
      stat_reg <= (stat_reg & ~clr_now()) | fault_now;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      mask_reg <= 4'h0;
    end else if (wr_take && req.addr == PCG_OFF_INT_MASK) begin
      mask_reg <= req.wdata[3:0] & PCG_INT_WMASK;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(((stat_reg & ~clr_now()) | fault_now) & mask_reg);
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  sequence s_access;
    PSEL && PENABLE && !PREADY;
  endsequence

  sequence s_answer;
    ##1 PREADY;
  endsequence

  sequence s_wdt_gated;
    UNIT_SEL[0] && !gates.wdt;
  endsequence

  a_gate_follow: assert property (
    !auto_sel |=> PWM_CLK_EN == $past(run_reg[PCG_BIT_PWM]))
    else $error("pwm enable does not follow run gate");
  a_fault_gated: assert property (
    UNIT_SEL[0] && !gates.wdt |=> UNIT_FAULT[0] && stat_reg[0])
    else $error("missing fault on gated watchdog access");
  a_fault_clocked: assert property (
    UNIT_SEL[1] && gates.hibernation_gate |=> !UNIT_FAULT[1])
    else $error("fault raised on clocked unit");
  a_reset_value: assert property (
    $past(SRST) |-> run_reg == 32'h0000_0040 && HIB_CLK_EN)
    else $error("run gate reset value wrong");
  a_resv_zero: assert property (
    (run_reg & ~PCG_GATE_WMASK) == 0 && (slp_reg & ~PCG_GATE_WMASK) == 0)
    else $error("reserved gate bits not zero");
  a_spd_clamp: assert property (
    ADC_SPEED <= MAX_SPD)
    else $error("adc speed above maximum");
  a_sleep_auto: assert property (
    auto_sel && pmode == PCG_PM_SLEEP |=> WDT_CLK_EN == $past(slp_reg[3]))
    else $error("sleep gate not applied");
  a_sleep_write: assert property (
    PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h110
      |=> slp_reg == ($past(PWDATA) & PCG_GATE_WMASK))
    else $error("sleep gate write lost");
  a_apb_wait: assert property (
    s_access |-> s_answer)
    else $error("apb answer not after one wait");
  a_hib_write: assert property (
    PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h100
      |=> run_reg[6] == $past(PWDATA[6]))
    else $error("hib gate bit not writable");
  a_wdt_write: assert property (
    PSEL && PENABLE && PREADY && PWRITE && PADDR == PCG_OFF_RUN_GATE
      |=> run_reg[PCG_BIT_WDT] == $past(PWDATA[PCG_BIT_WDT]))
    else $error("watchdog gate bit not writable");
  a_run_follow: assert property (
    !auto_sel |=> WDT_CLK_EN == $past(run_reg[PCG_BIT_WDT]) &&
                  ADC_CLK_EN == $past(run_reg[PCG_BIT_ADC]) &&
                  HIB_CLK_EN == $past(run_reg[PCG_BIT_HIB]))
    else $error("enables do not follow run gate");
  a_deep_auto: assert property (
    auto_sel && pmode == PCG_PM_DEEP
      |=> ADC_CLK_EN == $past(dslp_reg[PCG_BIT_ADC]))
    else $error("deep sleep gate not applied");
  a_speed_pass: assert property (
    !auto_sel && run_reg[PCG_SPD_LO +: 2] <= MAX_SPD
      |=> ADC_SPEED == $past(run_reg[PCG_SPD_LO +: 2]))
    else $error("adc speed field not applied");
  a_reset_clear: assert property (
    $past(SRST) |-> !PWM_CLK_EN && !ADC_CLK_EN && !WDT_CLK_EN &&
                    ADC_SPEED == 2'h0 && slp_reg == PCG_GATE_RESET)
    else $error("gate bits not cleared by reset");
  a_resv_read: assert property (
    PSEL && PENABLE && PREADY && !PWRITE &&
      (PADDR == PCG_OFF_RUN_GATE || PADDR == PCG_OFF_SLP_GATE)
      |-> (PRDATA & ~PCG_GATE_WMASK) == 32'h0)
    else $error("reserved bits read back nonzero");
  a_cfg_resv: assert property (
    (cfg_reg & ~PCG_CFG_WMASK) == 32'h0)
    else $error("reserved config bits not zero");
  a_set_wins: assert property (
    fault_now != 4'h0 |=> (stat_reg & $past(fault_now)) == $past(fault_now))
    else $error("fault flag lost against a clear");
  a_irq_level: assert property (
    1'b1 |=> IRQ == |(stat_reg & $past(mask_reg)))
    else $error("irq does not track masked status");
  a_fault_irq: assert property (
    s_wdt_gated ##0 mask_reg[0] |=> IRQ)
    else $error("masked-in fault raised no irq");

endmodule : pcg_top
`default_nettype wire

// file: hdl/pcg_pkg.sv
// pcg_pkg: shared constants, register layout and carrier types for the
// peripheral clock gating controller.
// assumes: single 50 MHz clock domain, APB register access.
package pcg_pkg;

  // --------------------------------------------------------------------
  // register offsets (byte addresses)
  // --------------------------------------------------------------------
  localparam logic [11:0] PCG_OFF_RUN_CFG   = 12'h060;
  localparam logic [11:0] PCG_OFF_RUN_GATE  = 12'h100;
  localparam logic [11:0] PCG_OFF_SLP_GATE  = 12'h110;
  localparam logic [11:0] PCG_OFF_DSLP_GATE = 12'h120;
  localparam logic [11:0] PCG_OFF_INT_STAT  = 12'h130;
  localparam logic [11:0] PCG_OFF_INT_MASK  = 12'h134;
  localparam logic [11:0] PCG_OFF_MODE      = 12'h138;

  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int PCG_BIT_WDT  = 3;
  localparam int PCG_BIT_HIB  = 6;
  localparam int PCG_SPD_LO   = 8;
  localparam int PCG_BIT_ADC  = 16;
  localparam int PCG_BIT_PWM  = 20;
  localparam int PCG_BIT_AUTO = 27;

  localparam logic [31:0] PCG_GATE_WMASK = 32'h0011_0348;
  localparam logic [31:0] PCG_GATE_RESET = 32'h0000_0040;
  localparam logic [31:0] PCG_CFG_WMASK  = 32'h0800_0000;
  localparam logic [31:0] PCG_CFG_RESET  = 32'h0000_0000;
  localparam logic [3:0]  PCG_INT_WMASK  = 4'hf;

  // sample speed encodings
  localparam logic [1:0] PCG_SPD_125K = 2'h0;
  localparam logic [1:0] PCG_SPD_250K = 2'h1;
  localparam logic [1:0] PCG_SPD_500K = 2'h2;

  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    PCG_PM_RUN   = 2'b00,
    PCG_PM_SLEEP = 2'b01,
    PCG_PM_DEEP  = 2'b10
  } pcg_pmode_t;

  typedef struct packed {
    logic       pwm;
    logic       adc;
    logic       hibernation_gate;
    logic       wdt;
    logic [1:0] spd;
  } pcg_gates_t;

  typedef struct packed {
    logic        sel;
    logic        en;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pcg_apb_req_t;

endpackage : pcg_pkg

// file: hdl/pcg_gate_sel.sv
// pcg_gate_sel: picks the active gating word from the power mode and
// the automatic gating select, clamps the adc speed.
// assumes: all inputs registered in the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module pcg_gate_sel
  import pcg_pkg::*;
#(
  parameter logic [1:0] MAX_SPD = 2'h2
) (
  // register contents
  input  wire logic [31:0]         run_word,
  input  wire logic [31:0]         slp_word,
  input  wire logic [31:0]         dslp_word,
  // mode
  input  wire logic                auto_sel,
  input  wire pcg_pkg::pcg_pmode_t pmode,
  // result
  output pcg_pkg::pcg_gates_t      gates
);

  import pcg_pkg::*;

  function automatic pcg_gates_t unpack_word(input logic [31:0] w);
    pcg_gates_t g;
    g.pwm = w[PCG_BIT_PWM];
    g.adc = w[PCG_BIT_ADC];
    g.hibernation_gate = w[PCG_BIT_HIB];
    g.wdt = w[PCG_BIT_WDT];
    // values above the ceiling are clamped, incl. the undefined 0x3
    g.spd = (w[PCG_SPD_LO +: 2] > MAX_SPD) ? MAX_SPD : w[PCG_SPD_LO +: 2];
    return g;
  endfunction : unpack_word

  always_comb begin
    logic [31:0] w;
    w = run_word;
    if (auto_sel) begin
      case (pmode)
        PCG_PM_SLEEP: w = slp_word;
        PCG_PM_DEEP:  w = dslp_word;
        default:      w = run_word;
      endcase
    end
    gates = unpack_word(w);
  end

endmodule : pcg_gate_sel
`default_nettype wire

// file: hdl/pcg_fault_chk.sv
// pcg_fault_chk: flags a peripheral access aimed at an unclocked unit.
// assumes: sel and gate flags are synchronous to the system clock.
`timescale 1ns/1ns
`default_nettype none
module pcg_fault_chk
  import pcg_pkg::*;
(
  // peripheral select strobes, one per unit: pwm, adc, hib, wdt
  input  wire logic [3:0]          unit_sel,
  input  wire pcg_pkg::pcg_gates_t gates,
  // result
  output logic [3:0]               unit_fault
);

  import pcg_pkg::*;

  always_comb begin
    unit_fault = unit_sel & ~{gates.pwm, gates.adc, gates.hibernation_gate, gates.wdt};
  end

endmodule : pcg_fault_chk
`default_nettype wire

// file: tb/pcg_top_bench.sv
// pcg_top_bench: self-checking bench for the clock gating controller.
// assumes: pcg_pkg and pcg_top compiled first; bench is the apb master.
`timescale 1ns/1ns
`default_nettype none
module pcg_top_bench;
  import pcg_pkg::*;

  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic        mclk;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  pwr_mode;
  logic [3:0]  unit_sel;
  logic [3:0]  unit_fault;
  logic        pwm_en;
  logic        adc_en;
  logic        hib_en;
  logic        wdt_en;
  logic [1:0]  adc_speed;
  logic        irq;
  int          fails;
  int          n_checks;
  int          cycles;

  pcg_top dut (
    .MCLK(mclk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PWR_MODE(pwr_mode),
    .UNIT_SEL(unit_sel), .UNIT_FAULT(unit_fault), .PWM_CLK_EN(pwm_en),
    .ADC_CLK_EN(adc_en), .HIB_CLK_EN(hib_en), .WDT_CLK_EN(wdt_en),
    .ADC_SPEED(adc_speed), .IRQ(irq)
  );

  always #10 mclk = ~mclk;

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // hang guard: whole run is well under a thousand transfers
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; waits for pready without assuming a latency
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic err_exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, err_exp});
  endtask : rd

  // enables settle one cycle after a write or a mode change
  task automatic en_chk(input logic [3:0] exp);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk({28'h0, pwm_en, adc_en, hib_en, wdt_en}, {28'h0, exp});
    // hand back on a rising edge so callers drive inputs there
    @(posedge mclk);
  endtask : en_chk

  // strobe units for one cycle, look at the fault one cycle later
  task automatic strobe(input logic [3:0] m, input logic [3:0] exp);
    @(posedge mclk);
    unit_sel <= m;
    @(posedge mclk);
    unit_sel <= 4'h0;
    @(negedge mclk);
    chk({28'h0, unit_fault}, {28'h0, exp});
    @(posedge mclk);
  endtask : strobe

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    en_chk(4'b0010);
    chk({30'h0, adc_speed}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(PCG_OFF_RUN_GATE, 32'h0000_0040, 1'b0);
    rd(PCG_OFF_SLP_GATE, 32'h0000_0040, 1'b0);
    rd(PCG_OFF_DSLP_GATE, 32'h0000_0040, 1'b0);
    rd(PCG_OFF_RUN_CFG, 32'h0, 1'b0);
  endtask : t_reset

  task automatic t_fields;
    logic [1:0] s;
    wr(PCG_OFF_RUN_GATE, 32'hffff_ffff);
    rd(PCG_OFF_RUN_GATE, 32'h0011_0348, 1'b0);
    en_chk(4'b1111);
    chk({30'h0, adc_speed}, 32'h2);
    for (int i = 0; i < 3; i++) begin
      s = 2'(i);
      wr(PCG_OFF_RUN_GATE, {22'h0, s, 8'h48});
      en_chk(4'b0011);
      chk({30'h0, adc_speed}, {30'h0, s});
    end
    rd(PCG_OFF_SLP_GATE, 32'h0000_0040, 1'b0);
    wr(PCG_OFF_SLP_GATE, 32'hffff_ffff);
    rd(PCG_OFF_SLP_GATE, 32'h0011_0348, 1'b0);
    wr(PCG_OFF_DSLP_GATE, 32'hffff_ffff);
    rd(PCG_OFF_DSLP_GATE, 32'h0011_0348, 1'b0);
    rd(PCG_OFF_RUN_GATE, 32'h0000_0248, 1'b0);
  endtask : t_fields

  task automatic t_unmapped;
    wr(PCG_OFF_RUN_GATE, 32'h0000_0048);
    apb_bad();
    rd(12'h200, 32'h0, 1'b1);
    rd(PCG_OFF_RUN_GATE, 32'h0000_0048, 1'b0);
  endtask : t_unmapped

  task automatic apb_bad;
    logic [31:0] r;
    logic        e;
    apb(1'b1, 12'h200, 32'h0000_0000, r, e);
    chk({31'h0, e}, 32'h1);
  endtask : apb_bad

  task automatic t_fault;
    wr(PCG_OFF_INT_MASK, 32'h0);
    wr(PCG_OFF_RUN_GATE, 32'h0);
    en_chk(4'b0000);
    for (int i = 0; i < 4; i++) begin
      strobe(4'(1 << i), 4'(1 << i));
    end
    chk({31'h0, irq}, 32'h0);
    rd(PCG_OFF_INT_STAT, 32'h0000_000f, 1'b0);
    wr(PCG_OFF_INT_MASK, 32'h1);
    rd(PCG_OFF_INT_MASK, 32'h0000_0001, 1'b0);
    en_chk(4'b0000);
    chk({31'h0, irq}, 32'h1);
    wr(PCG_OFF_INT_STAT, 32'h1);
    en_chk(4'b0000);
    chk({31'h0, irq}, 32'h0);
    rd(PCG_OFF_INT_STAT, 32'h0000_000e, 1'b0);
    wr(PCG_OFF_RUN_GATE, 32'h0011_0048);
    en_chk(4'b1111);
    strobe(4'hf, 4'h0);
    rd(PCG_OFF_INT_STAT, 32'h0000_000e, 1'b0);
  endtask : t_fault

  task automatic t_modes;
    wr(PCG_OFF_RUN_GATE, 32'h0000_0048);
    wr(PCG_OFF_SLP_GATE, 32'h0010_0000);
    wr(PCG_OFF_DSLP_GATE, 32'h0001_0000);
    rd(PCG_OFF_SLP_GATE, 32'h0010_0000, 1'b0);
    pwr_mode <= 2'h1;
    en_chk(4'b0011);
    pwr_mode <= 2'h2;
    en_chk(4'b0011);
    wr(PCG_OFF_RUN_CFG, 32'hffff_ffff);
    rd(PCG_OFF_RUN_CFG, 32'h0800_0000, 1'b0);
    en_chk(4'b0100);
    pwr_mode <= 2'h1;
    en_chk(4'b1000);
    rd(PCG_OFF_MODE, 32'h0000_0005, 1'b0);
    strobe(4'b0001, 4'b0001);
    pwr_mode <= 2'h3;
    en_chk(4'b0011);
    rd(PCG_OFF_MODE, 32'h0000_0004, 1'b0);
    pwr_mode <= 2'h2;
    en_chk(4'b0100);
    pwr_mode <= 2'h0;
    en_chk(4'b0011);
  endtask : t_modes

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    mclk     = 1'b0;
    srst     = 1'b1;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h0;
    pwdata   = 32'h0;
    pwr_mode = 2'h0;
    unit_sel = 4'h0;
    fails    = 0;
    n_checks = 0;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_fields();
    t_unmapped();
    t_fault();
    t_modes();
    summarize();
  end
endmodule : pcg_top_bench
`default_nettype wire
